//--- include/asu_pkg.sv
package asu_pkg;
    // mode register bit positions
    localparam int MODE_POWER_BIT = 7;
    localparam int MODE_TXE_BIT = 6;
    localparam int MODE_RXE_BIT = 5;
    // status register bit positions of the buffer-full and shifter-busy flags
    localparam int STAT_TXBF_BIT = 1;
    localparam int STAT_TXSF_BIT = 0;
    // reset values
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] TXB_RESET = 8'hFF;
    localparam logic [7:0] RXB_RESET = 8'hFF;
    // default bit period in operating clocks
    localparam int BAUD_DIV_DEFAULT = 16;
    // extra gap after stop bit during back-to-back frames, in operating clocks
    localparam int BTB_GAP_CLKS = 2;
    localparam int DATA_BITS = 8;
    typedef enum logic [4:0] {
        ASU_TX_IDLE  = 5'b00001,
        ASU_TX_START = 5'b00010,
        ASU_TX_DATA  = 5'b00100,
        ASU_TX_STOP  = 5'b01000,
        ASU_TX_GAP   = 5'b10000
    } asu_tx_state_t;
    typedef enum logic [3:0] {
        ASU_RX_IDLE  = 4'b0001,
        ASU_RX_START = 4'b0010,
        ASU_RX_DATA  = 4'b0100,
        ASU_RX_STOP  = 4'b1000
    } asu_rx_state_t;
endpackage

//--- logic/asu_rx.sv
`timescale 1ns/1ps
module asu_rx
    import asu_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_run,
    input wire logic [DIV_W-1:0] i_div,
    input wire logic i_rxd,
    output logic o_done,
    output logic o_frame_err,
    output logic [7:0] o_data
);
    asu_rx_state_t st_ff, nxt_st;
    logic [DIV_W-1:0] cnt_ff, nxt_cnt;
    logic [2:0] bit_ff, nxt_bit;
    logic [7:0] sh_ff, nxt_sh;
    logic [7:0] data_ff, nxt_data;
    logic done_ff, nxt_done;
    logic ferr_ff, nxt_ferr;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_data = data_ff;
        nxt_done = 1'b0;
        nxt_ferr = ferr_ff;
        if (!i_run) begin
            nxt_st = ASU_RX_IDLE;
        end else begin
            unique case (st_ff)
                ASU_RX_IDLE: begin
                    // timing restarts on every start edge
                    if (!i_rxd) begin
                        nxt_st = ASU_RX_START;
                        nxt_cnt = DIV_W'(i_div >> 1);
                    end
                end
                ASU_RX_START: begin
                    if (cnt_ff == '0) begin
                        if (i_rxd) begin
                            // glitch, not a start bit
                            nxt_st = ASU_RX_IDLE;
                        end else begin
                            nxt_st = ASU_RX_DATA;
                            nxt_cnt = DIV_W'(i_div - 1'b1);
                            nxt_bit = '0;
                        end
                    end else begin
                        nxt_cnt = DIV_W'(cnt_ff - 1'b1);
                    end
                end
                ASU_RX_DATA: begin
                    if (cnt_ff == '0) begin
                        nxt_sh = {i_rxd, sh_ff[7:1]};
                        nxt_cnt = DIV_W'(i_div - 1'b1);
                        nxt_bit = 3'(bit_ff + 1'b1);
                        if (bit_ff == 3'(DATA_BITS - 1)) begin
                            nxt_st = ASU_RX_STOP;
                        end
                    end else begin
                        nxt_cnt = DIV_W'(cnt_ff - 1'b1);
                    end
                end
                ASU_RX_STOP: begin
                    if (cnt_ff == '0) begin
                        nxt_st = ASU_RX_IDLE;
                        nxt_data = sh_ff;
                        nxt_done = 1'b1;
                        nxt_ferr = !i_rxd;
                    end else begin
                        nxt_cnt = DIV_W'(cnt_ff - 1'b1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= ASU_RX_IDLE;
            cnt_ff <= '0;
            bit_ff <= '0;
            sh_ff <= '0;
            data_ff <= RXB_RESET;
            done_ff <= 1'b0;
            ferr_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            data_ff <= nxt_data;
            done_ff <= nxt_done;
            ferr_ff <= nxt_ferr;
        end
    end

    assign o_done = done_ff;
    assign o_frame_err = ferr_ff;
    assign o_data = data_ff;
endmodule

//--- logic/asu_top.sv
`timescale 1ns/1ps
module asu_top
    import asu_pkg::*;
#(
    parameter int DIV_W = 16,
    parameter logic [15:0] BAUD_DIV = 16'(BAUD_DIV_DEFAULT)
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_unit_power_bit,
    input wire logic i_tx_enable_bit,
    input wire logic i_rx_enable_bit,
    input wire logic i_tx_invert,
    input wire logic [DIV_W-1:0] i_bit_div,
    input wire logic i_tx_holding_buffer_wr,
    input wire logic [7:0] i_tx_holding_buffer_data,
    input wire logic i_serial_rx_pin,
    output logic o_serial_tx_pin,
    output logic [7:0] o_tx_status_register,
    output logic [7:0] o_serial_mode_register,
    output logic [7:0] o_rx_data,
    output logic o_rx_done,
    output logic o_rx_frame_err,
    output logic o_tx_done
);
    ////////////////////////////////////////////////////////////////////////
    // control: registers just hold; a stopped clock freezes them as-is
    logic [7:0] mode_ff, nxt_mode;
    logic tx_run, rx_run;
    logic [DIV_W-1:0] div_eff;

    // zero divider would lock the counters, so fall back to the default
    assign div_eff = (i_bit_div == '0) ? DIV_W'(BAUD_DIV) : i_bit_div;

    always_comb begin
        nxt_mode = MODE_RESET;
        nxt_mode[MODE_POWER_BIT] = i_unit_power_bit;
        nxt_mode[MODE_TXE_BIT] = i_tx_enable_bit;
        nxt_mode[MODE_RXE_BIT] = i_rx_enable_bit;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_ff <= MODE_RESET;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // enables act only with power, so the power-first order is honoured
    assign tx_run = mode_ff[MODE_POWER_BIT] && mode_ff[MODE_TXE_BIT];
    assign rx_run = mode_ff[MODE_POWER_BIT] && mode_ff[MODE_RXE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // receive pin synchroniser
    logic rx_s1_ff, rx_s2_ff;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else begin
            rx_s1_ff <= i_serial_rx_pin;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    // received data taken from the two-flop synchronised pin, never inverted
    asu_rx #(
        .DIV_W(DIV_W)
    ) u_rx (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_run(rx_run),
        .i_div(div_eff),
        .i_rxd(rx_s2_ff),
        .o_done(o_rx_done),
        .o_frame_err(o_rx_frame_err),
        .o_data(o_rx_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer and shifter
    asu_tx_state_t st_ff, nxt_st;
    logic [7:0] txb_ff, nxt_txb;
    logic txbf_ff, nxt_txbf;
    logic [7:0] sh_ff, nxt_sh;
    logic [DIV_W-1:0] cnt_ff, nxt_cnt;
    logic [2:0] bit_ff, nxt_bit;
    logic line_ff, nxt_line;
    logic pin_ff, nxt_pin;
    logic tdone_ff, nxt_tdone;
    logic load;

    // a buffered byte moves into the shifter from idle or at the gap's last clock
    assign load = txbf_ff && tx_run && ((st_ff == ASU_TX_IDLE) || ((st_ff == ASU_TX_GAP) && (cnt_ff == '0)));

    always_comb begin
        nxt_st = st_ff;
        nxt_txb = txb_ff;
        nxt_txbf = txbf_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_line = line_ff;
        nxt_tdone = 1'b0;
        if (load) begin
            nxt_txbf = 1'b0;
        end
        // write after load in same cycle: set wins
        if (i_tx_holding_buffer_wr && tx_run) begin
            nxt_txb = i_tx_holding_buffer_data;
            nxt_txbf = 1'b1;
        end
        if (!tx_run) begin
            nxt_st = ASU_TX_IDLE;
            nxt_line = 1'b1;
            nxt_txbf = 1'b0;
        end else begin
            unique case (st_ff)
                ASU_TX_IDLE: begin
                    if (load) begin
                        nxt_sh = txb_ff;
                        nxt_st = ASU_TX_START;
                        nxt_line = 1'b0;
                        nxt_cnt = DIV_W'(div_eff - 1'b1);
                    end
                end
                ASU_TX_START: begin
                    if (cnt_ff == '0) begin
                        nxt_st = ASU_TX_DATA;
                        nxt_line = sh_ff[0];
                        nxt_bit = '0;
                        nxt_cnt = DIV_W'(div_eff - 1'b1);
                    end else begin
                        nxt_cnt = DIV_W'(cnt_ff - 1'b1);
                    end
                end
                ASU_TX_DATA: begin
                    if (cnt_ff == '0) begin
                        nxt_cnt = DIV_W'(div_eff - 1'b1);
                        if (bit_ff == 3'(DATA_BITS - 1)) begin
                            nxt_st = ASU_TX_STOP;
                            nxt_line = 1'b1;
                        end else begin
                            nxt_sh = {1'b1, sh_ff[7:1]};
                            nxt_line = sh_ff[1];
                            nxt_bit = 3'(bit_ff + 1'b1);
                        end
                    end else begin
                        nxt_cnt = DIV_W'(cnt_ff - 1'b1);
                    end
                end
                ASU_TX_STOP: begin
                    if (cnt_ff == '0) begin
                        nxt_tdone = 1'b1;
                        nxt_st = ASU_TX_GAP;
                        // two idle clocks; the next start loads at the gap's end, not via idle
                        nxt_cnt = DIV_W'(BTB_GAP_CLKS - 1);
                    end else begin
                        nxt_cnt = DIV_W'(cnt_ff - 1'b1);
                    end
                end
                ASU_TX_GAP: begin
                    if (cnt_ff == '0) begin
                        if (load) begin
                            // back to back: no extra idle cycle beyond the gap
                            nxt_sh = txb_ff;
                            nxt_st = ASU_TX_START;
                            nxt_line = 1'b0;
                            nxt_cnt = DIV_W'(div_eff - 1'b1);
                        end else begin
                            nxt_st = ASU_TX_IDLE;
                        end
                    end else begin
                        nxt_cnt = DIV_W'(cnt_ff - 1'b1);
                    end
                end
            endcase
        end
        nxt_pin = i_tx_invert ? !nxt_line : nxt_line;
    end

    // no clock, no edge: every flop including the pin simply holds
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= ASU_TX_IDLE;
            txb_ff <= TXB_RESET;
            txbf_ff <= 1'b0;
            sh_ff <= '0;
            cnt_ff <= '0;
            bit_ff <= '0;
            line_ff <= 1'b1;
            pin_ff <= 1'b1;
            tdone_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            txb_ff <= nxt_txb;
            txbf_ff <= nxt_txbf;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            line_ff <= nxt_line;
            pin_ff <= nxt_pin;
            tdone_ff <= nxt_tdone;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status outputs
    logic [7:0] stat_ff, nxt_stat;

    always_comb begin
        nxt_stat = '0;
        nxt_stat[STAT_TXBF_BIT] = nxt_txbf;
        // gap counts as busy: a byte written then waits for the gap's end
        nxt_stat[STAT_TXSF_BIT] = (nxt_st != ASU_TX_IDLE);
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign o_serial_tx_pin = pin_ff;
    assign o_tx_status_register = stat_ff;
    assign o_serial_mode_register = mode_ff;
    assign o_tx_done = tdone_ff;
endmodule

//--- tb/asu_top_chk.sv
`timescale 1ns/1ps
module asu_top_chk (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_unit_power_bit,
    input wire logic i_tx_invert,
    input wire logic i_tx_holding_buffer_wr,
    input wire logic o_serial_tx_pin,
    input wire logic [7:0] o_tx_status_register,
    input wire logic [7:0] o_serial_mode_register,
    input wire logic [7:0] o_rx_data,
    input wire logic o_rx_done,
    input wire logic o_tx_done
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    wire logic run = o_serial_mode_register[7] & o_serial_mode_register[6];
    ////////////////////////////////////////////////////////////////
    flag_set_a: assert property ((i_tx_holding_buffer_wr && run) |=> o_tx_status_register[1])
        else $error("buffer full not set");
    flag_load_a: assert property (($rose(o_tx_status_register[1]) && !i_tx_holding_buffer_wr
        && !o_tx_status_register[0] && run) |=> !o_tx_status_register[1]) else $error("byte not loaded");
    flag_ignore_a: assert property ((!run && !o_tx_status_register[1]) |=> !o_tx_status_register[1])
        else $error("write taken while stopped");
    status_zero_a: assert property (o_tx_status_register[7:2] == 6'h00) else $error("status spare bits");
    // pin register lags the invert input by one edge, hence the stable term
    idle_level_a: assert property ((run && $past(run) && o_tx_status_register == 8'h00
        && $past(o_tx_status_register) == 8'h00 && $stable(i_tx_invert)) |-> o_serial_tx_pin == !i_tx_invert)
        else $error("idle level wrong");
    start_bit_a: assert property ((i_tx_holding_buffer_wr && run && o_tx_status_register == 8'h00)
        |-> ##[1:3] (o_serial_tx_pin == i_tx_invert && o_tx_status_register[0])) else $error("no start bit");
    tx_done_a: assert property (o_tx_done |-> (o_serial_tx_pin ^ i_tx_invert) ##1 !o_tx_done)
        else $error("bad end of stop bit");
    rx_done_a: assert property (o_rx_done |-> o_serial_mode_register[7] && o_serial_mode_register[5]
        ##1 !o_rx_done) else $error("bad receive pulse");
    rx_hold_a: assert property ($changed(o_rx_data) |-> o_rx_done) else $error("data moved alone");
    mode_power_a: assert property (o_serial_mode_register[7] == $past(i_unit_power_bit))
        else $error("power bit not taken");
endmodule
bind asu_top asu_top_chk i_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_unit_power_bit(i_unit_power_bit),
    .i_tx_invert(i_tx_invert), .i_tx_holding_buffer_wr(i_tx_holding_buffer_wr),
    .o_serial_tx_pin(o_serial_tx_pin), .o_tx_status_register(o_tx_status_register),
    .o_serial_mode_register(o_serial_mode_register), .o_rx_data(o_rx_data),
    .o_rx_done(o_rx_done), .o_tx_done(o_tx_done)
);

//--- tb/asu_line_peer.sv
`timescale 1ns/1ps
module asu_line_peer (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_txd,
    input wire logic i_inv,
    input wire logic [15:0] i_div,
    output logic o_rxd
);
    logic [7:0] got[$];
    int st[$];
    int cyc = 0;
    int t;
    logic [7:0] b;
    initial o_rxd = 1'b1;
    always @(posedge i_clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////
    // mid-start recheck drops the false start seen when polarity flips
    initial begin
        forever begin
            @(posedge i_clk);
            if (i_rstn && (i_txd ^ i_inv) == 1'b0) begin
                t = cyc;
                repeat (i_div / 2) @(posedge i_clk);
                if ((i_txd ^ i_inv) == 1'b0) begin
                    for (int k = 0; k < 8; k++) begin
                        repeat (i_div) @(posedge i_clk);
                        b[k] = i_txd ^ i_inv;
                    end
                    repeat (i_div) @(posedge i_clk);
                    got.push_back(b);
                    st.push_back(t);
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic send(input logic [7:0] v, input int gap);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(negedge i_clk);
            o_rxd = f[k];
            repeat (i_div - 1) @(negedge i_clk);
        end
        repeat (gap) @(negedge i_clk);
    endtask
endmodule

//--- tb/asu_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module asu_top_tb;
    import asu_pkg::*;
    localparam int DIV = 8;
    logic i_ref_clk = 1'b0;
    logic clk_on = 1'b1;
    logic i_rstn = 1'b0;
    logic pwr = 1'b0, txe = 1'b0, rxe = 1'b0, inv = 1'b0, wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rxd, txd, rxdone, rxerr, txdone;
    logic [7:0] stat, mode, rxdat, held, sheld;
    logic [7:0] rx_last = 8'h00;
    logic [7:0] pat[3] = '{8'h01, 8'h80, 8'hFE};
    int rx_n = 0, ncyc = 0, n0, n_errors = 0, checks_done = 0;
    asu_top i_dut (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_unit_power_bit(pwr), .i_tx_enable_bit(txe),
        .i_rx_enable_bit(rxe), .i_tx_invert(inv), .i_bit_div(16'(DIV)), .i_tx_holding_buffer_wr(wr),
        .i_tx_holding_buffer_data(wdata), .i_serial_rx_pin(rxd), .o_serial_tx_pin(txd),
        .o_tx_status_register(stat), .o_serial_mode_register(mode), .o_rx_data(rxdat),
        .o_rx_done(rxdone), .o_rx_frame_err(rxerr), .o_tx_done(txdone)
    );
    asu_line_peer i_peer (
        .i_clk(i_ref_clk), .i_rstn(i_rstn), .i_txd(txd), .i_inv(inv), .i_div(16'(DIV)), .o_rxd(rxd)
    );
    initial begin
        forever begin
            #50;
            if (clk_on) i_ref_clk = ~i_ref_clk;
        end
    end
    always @(posedge i_ref_clk) begin
        ncyc <= ncyc + 1;
        if (rxdone === 1'b1) begin
            rx_last <= rxdat;
            rx_n <= rx_n + 1;
        end
        if (ncyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // each write carries a fresh byte, never a refresh
    task automatic put(input logic [7:0] v, input logic full);
        @(negedge i_ref_clk);
        wr = 1'b1;
        wdata = v;
        @(negedge i_ref_clk);
        wr = 1'b0;
        `CHK(stat[STAT_TXBF_BIT], full)
    endtask
    task automatic wait_free();
        for (int k = 0; k < 2000 && stat[STAT_TXBF_BIT] !== 1'b0; k++) @(negedge i_ref_clk);
    endtask
    task automatic wait_peer(input int n);
        for (int k = 0; k < 3000 && i_peer.got.size() < n; k++) @(negedge i_ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge i_ref_clk);
        `CHK(mode, MODE_RESET)
        `CHK(stat, 8'h00)
        `CHK(rxdat, RXB_RESET)
        `CHK(txd, 1'b1)
        repeat (4) @(negedge i_ref_clk);
        i_rstn = 1'b1;
        $display("test reset done");
        repeat (2) @(negedge i_ref_clk);
        pwr = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        put(8'h5A, 1'b0);
        txe = 1'b1;
        rxe = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        `CHK(mode, 8'hE0 | MODE_RESET)
        $display("test enable done");
        // no lin bus on this line, so continuous sending is allowed
        n0 = i_peer.got.size();
        put(8'hA5, 1'b1);
        wait_free();
        put(8'h3C, 1'b1);
        wait_peer(n0 + 2);
        `CHK(i_peer.got[n0], 8'hA5)
        `CHK(i_peer.got[n0 + 1], 8'h3C)
        `CHK(i_peer.st[n0 + 1] - i_peer.st[n0], 10 * DIV + BTB_GAP_CLKS)
        $display("test back to back done");
        inv = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        `CHK(txd, 1'b0)
        n0 = i_peer.got.size();
        put(8'hC3, 1'b1);
        wait_peer(n0 + 1);
        `CHK(i_peer.got[n0], 8'hC3)
        n0 = rx_n;
        for (int k = 0; k < 3; k++) begin
            i_peer.send(pat[k], k * 3);
            repeat (2) @(negedge i_ref_clk);
            `CHK(rx_last, pat[k])
            `CHK(rxerr, 1'b0)
        end
        `CHK(rx_n, n0 + 3)
        $display("test invert and receive done");
        inv = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        put(8'h55, 1'b1);
        repeat (30) @(negedge i_ref_clk);
        held = {7'h00, txd};
        sheld = stat;
        clk_on = 1'b0;
        #5010;
        `CHK({7'h00, txd}, held)
        `CHK(stat, sheld)
        clk_on = 1'b1;
        @(negedge i_ref_clk);
        txe = 1'b0;
        rxe = 1'b0;
        @(negedge i_ref_clk);
        pwr = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        `CHK(mode, MODE_RESET)
        $display("test clock stop done");
        conclude();
    end
endmodule
